// >>> core/rps_pkg.sv
// Constants shared by the remappable pin select block.
// Assumes a 32-bit APB slave port and 16-bit registers in the low half of each word.
//
// Function
// - The pin number in bits 13 to 8 of the first SPI3 input selector drives the SPI3 clock input.
// - The pin number in bits 5 to 0 of the first SPI3 input selector drives the SPI3 data input.
// - Bits 5 to 0 of the second SPI3 selector choose the select input pin, bits 15 to 6 are absent.
// - Bits 15 to 14 and 7 to 6 of two-field registers ignore writes and read as zero.
// - Each six-bit output field drives its pin from the peripheral output of that function number, or from the port data when the field is zero.
// - On the 64-pin variant the field for output pin 5 ignores writes and reads as zero.
// - On the 64-pin variant the field for output pin 15 ignores writes and reads as zero.
package rps_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses, one aligned word per register)
   // ----------------------------------------------------------------
   localparam logic [11:0] OFF_SPI3_CLK_DATA_SEL = 12'h000;
   localparam logic [11:0] OFF_SPI3_SELECT_SEL   = 12'h004;
   localparam logic [11:0] OFF_OUT_MAP_BASE      = 12'h008;
   localparam int unsigned OUT_MAP_REGS          = 9;
   localparam int unsigned OUT_PINS              = 2 * OUT_MAP_REGS;

   // Register index codes returned by the address decoder
   localparam logic [3:0]  IDX_CLK_DATA          = 4'h0;
   localparam logic [3:0]  IDX_SELECT            = 4'h1;
   localparam logic [3:0]  IDX_MAP_FIRST         = 4'h2;
   localparam logic [3:0]  IDX_NONE              = 4'hf;

   // ----------------------------------------------------------------
   // Field layout and reset values
   // ----------------------------------------------------------------
   localparam int unsigned FIELD_W               = 6;
   localparam int unsigned LO_LSB                = 0;
   localparam int unsigned HI_LSB                = 8;
   localparam logic [5:0]  SEL_RESET             = 6'h3f;
   localparam logic [5:0]  MAP_RESET             = 6'h00;
   localparam logic [5:0]  FUNC_PORT             = 6'h00;

   // Output pins whose fields are absent on the small package
   localparam int unsigned PIN_ABSENT_A          = 5;
   localparam int unsigned PIN_ABSENT_B          = 15;

endpackage : rps_pkg

// >>> core/rps_sync.sv
// Two flip-flop synchroniser for a bus of independent pin levels.
// Assumes each bit is a slow level; no bus coherence is implied.
module rps_sync #(
   parameter int unsigned WIDTH = 1
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Asynchronous levels in, synchronised levels out
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= d;
         sync_q <= meta_q;
      end
   end

   assign q = sync_q;

endmodule : rps_sync

// >>> core/rps_pin_select.sv
// Remappable pin select: SPI3 input selectors and output pin mapping.
// Assumes an APB master on pclk, pins arriving asynchronously and
// peripheral outputs and port data coming from logic on pclk.
//
// The placing of the registers and the APB register port are this design's own decisions.
module rps_pin_select #(
   parameter int unsigned NUM_IN_PINS = 64,
   parameter int unsigned NUM_FUNCS   = 64,
   parameter bit          PKG_64PIN   = 1'b0,
   parameter int unsigned ADDR_W      = 12
) (
   // Clock and reset
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   // APB slave
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [ADDR_W-1:0]           paddr,
   input  wire logic [31:0]                 pwdata,
   input  wire logic [3:0]                  pstrb,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   // Remappable input pins
   input  wire logic [NUM_IN_PINS-1:0]      remappable_io_pin_in,
   // Routed SPI3 inputs
   output logic                             spi3_clock_input,
   output logic                             spi3_data_input,
   output logic                             spi3_select_input,
   // Peripheral outputs by function number and ordinary port data
   input  wire logic [NUM_FUNCS-1:0]        periph_out,
   input  wire logic [rps_pkg::OUT_PINS-1:0] port_data,
   // Remappable output pins
   output logic      [rps_pkg::OUT_PINS-1:0] remappable_io_pin_out,
   output logic      [rps_pkg::OUT_PINS-1:0] remap_active
);

   localparam int unsigned NP = rps_pkg::OUT_PINS;
   localparam int unsigned FW = rps_pkg::FIELD_W;

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   if (NUM_IN_PINS < 1 || NUM_IN_PINS > 64) begin : g_bad_pins
      $error("NUM_IN_PINS must lie in 1..64");
   end
   if (NUM_FUNCS < 1 || NUM_FUNCS > 64) begin : g_bad_funcs
      $error("NUM_FUNCS must lie in 1..64");
   end
   if (ADDR_W < 6 || ADDR_W > 12) begin : g_bad_addr
      $error("ADDR_W must lie in 6..12");
   end

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   // Byte address to register index; misaligned or unmapped gives none
   function automatic logic [3:0] reg_index(input logic [ADDR_W-1:0] a);
      logic [11:0] full;
      logic [11:0] rel;
      full = 12'(a);
      rel  = full - rps_pkg::OFF_OUT_MAP_BASE;
      reg_index = rps_pkg::IDX_NONE;
      if (full == rps_pkg::OFF_SPI3_CLK_DATA_SEL) begin
         reg_index = rps_pkg::IDX_CLK_DATA;
      end else if (full == rps_pkg::OFF_SPI3_SELECT_SEL) begin
         reg_index = rps_pkg::IDX_SELECT;
      end else if (full >= rps_pkg::OFF_OUT_MAP_BASE && rel[1:0] == 2'h0
                   && rel[11:2] < 10'(rps_pkg::OUT_MAP_REGS)) begin
         reg_index = rps_pkg::IDX_MAP_FIRST + 4'(rel[5:2]);
      end
   endfunction : reg_index

   // Whether the mapping field of output pin p exists on this package
   function automatic logic field_present(input int unsigned p);
      field_present = !(PKG_64PIN && (p == rps_pkg::PIN_ABSENT_A
                                      || p == rps_pkg::PIN_ABSENT_B));
   endfunction : field_present

   // ----------------------------------------------------------------
   // Pin synchroniser
   // ----------------------------------------------------------------
   logic [NUM_IN_PINS-1:0] pin_s;

   rps_sync #(
      .WIDTH (NUM_IN_PINS)
   ) u_pin_sync (
      .clk   (pclk),
      .rst_n (presetn),
      .d     (remappable_io_pin_in),
      .q     (pin_s)
   );

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   logic [FW-1:0] clk_sel_q;
   logic [FW-1:0] clk_sel_d;
   logic [FW-1:0] dat_sel_q;
   logic [FW-1:0] dat_sel_d;
   logic [FW-1:0] ss_sel_q;
   logic [FW-1:0] ss_sel_d;
   logic [FW-1:0] map_q [NP];
   logic [FW-1:0] map_d [NP];
   logic [31:0]   prdata_q;
   logic [31:0]   prdata_d;

   logic [3:0]    idx;
   logic          wr_en;
   logic          setup;

   assign idx   = reg_index(paddr);
   assign setup = psel && !penable;
   // A write lands only at the completing access edge
   assign wr_en = psel && penable && pwrite && (idx != rps_pkg::IDX_NONE);

   always_comb begin
      clk_sel_d = clk_sel_q;
      dat_sel_d = dat_sel_q;
      ss_sel_d  = ss_sel_q;
      if (wr_en && idx == rps_pkg::IDX_CLK_DATA) begin
         if (pstrb[1]) begin
            clk_sel_d = pwdata[rps_pkg::HI_LSB +: FW];
         end
         if (pstrb[0]) begin
            dat_sel_d = pwdata[rps_pkg::LO_LSB +: FW];
         end
      end
      if (wr_en && idx == rps_pkg::IDX_SELECT && pstrb[0]) begin
         ss_sel_d = pwdata[rps_pkg::LO_LSB +: FW];
      end
   end

   always_comb begin
      for (int unsigned p = 0; p < NP; p++) begin
         map_d[p] = map_q[p];
         if (wr_en && field_present(p)
             && idx == rps_pkg::IDX_MAP_FIRST + 4'(p / 2)) begin
            if (p % 2 == 1 && pstrb[1]) begin
               map_d[p] = pwdata[rps_pkg::HI_LSB +: FW];
            end else if (p % 2 == 0 && pstrb[0]) begin
               map_d[p] = pwdata[rps_pkg::LO_LSB +: FW];
            end
         end
      end
   end

   // Read data is captured in the setup cycle so prdata comes from a flop
   always_comb begin
      prdata_d = prdata_q;
      if (setup) begin
         prdata_d = '0;
         if (idx == rps_pkg::IDX_CLK_DATA) begin
            prdata_d[rps_pkg::HI_LSB +: FW] = clk_sel_q;
            prdata_d[rps_pkg::LO_LSB +: FW] = dat_sel_q;
         end else if (idx == rps_pkg::IDX_SELECT) begin
            prdata_d[rps_pkg::LO_LSB +: FW] = ss_sel_q;
         end else begin
            for (int unsigned p = 0; p < NP; p++) begin
               if (idx == rps_pkg::IDX_MAP_FIRST + 4'(p / 2)) begin
                  if (p % 2 == 1) begin
                     prdata_d[rps_pkg::HI_LSB +: FW] = map_q[p];
                  end else begin
                     prdata_d[rps_pkg::LO_LSB +: FW] = map_q[p];
                  end
               end
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_sel_q <= rps_pkg::SEL_RESET;
         dat_sel_q <= rps_pkg::SEL_RESET;
         ss_sel_q  <= rps_pkg::SEL_RESET;
         prdata_q  <= '0;
      end else begin
         clk_sel_q <= clk_sel_d;
         dat_sel_q <= dat_sel_d;
         ss_sel_q  <= ss_sel_d;
         prdata_q  <= prdata_d;
      end
   end

   // Absent fields never leave reset, so they read as zero
   for (genvar g = 0; g < NP; g++) begin : g_map
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            map_q[g] <= rps_pkg::MAP_RESET;
         end else begin
            map_q[g] <= map_d[g];
         end
      end
   end

   // Zero wait states: the access phase always completes at once
   assign pready  = psel && penable;
   assign pslverr = psel && penable && (idx == rps_pkg::IDX_NONE);
   assign prdata  = prdata_q;

   // ----------------------------------------------------------------
   // Input routing to SPI3
   // ----------------------------------------------------------------
   logic spi_clk_q;
   logic spi_clk_d;
   logic spi_dat_q;
   logic spi_dat_d;
   logic spi_ss_q;
   logic spi_ss_d;

   // A selector naming a pin that does not exist yields an idle high level
   always_comb begin
      spi_clk_d = 1'b1;
      spi_dat_d = 1'b1;
      spi_ss_d  = 1'b1;
      for (int unsigned i = 0; i < NUM_IN_PINS; i++) begin
         if (clk_sel_q == 6'(i)) begin
            spi_clk_d = pin_s[i];
         end
         if (dat_sel_q == 6'(i)) begin
            spi_dat_d = pin_s[i];
         end
         if (ss_sel_q == 6'(i)) begin
            spi_ss_d = pin_s[i];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         spi_clk_q <= 1'b1;
         spi_dat_q <= 1'b1;
         spi_ss_q  <= 1'b1;
      end else begin
         spi_clk_q <= spi_clk_d;
         spi_dat_q <= spi_dat_d;
         spi_ss_q  <= spi_ss_d;
      end
   end

   assign spi3_clock_input  = spi_clk_q;
   assign spi3_data_input   = spi_dat_q;
   assign spi3_select_input = spi_ss_q;

   // ----------------------------------------------------------------
   // Output mapping
   // ----------------------------------------------------------------
   logic [NP-1:0] pin_out_q;
   logic [NP-1:0] pin_out_d;
   logic [NP-1:0] active_q;
   logic [NP-1:0] active_d;

   // Function numbers beyond the implemented peripherals drive low
   always_comb begin
      for (int unsigned p = 0; p < NP; p++) begin
         active_d[p]  = (map_q[p] != rps_pkg::FUNC_PORT);
         pin_out_d[p] = port_data[p];
         if (active_d[p]) begin
            pin_out_d[p] = 1'b0;
            for (int unsigned f = 1; f < NUM_FUNCS; f++) begin
               if (map_q[p] == 6'(f)) begin
                  pin_out_d[p] = periph_out[f];
               end
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_out_q <= '0;
         active_q  <= '0;
      end else begin
         pin_out_q <= pin_out_d;
         active_q  <= active_d;
      end
   end

   assign remappable_io_pin_out = pin_out_q;
   assign remap_active          = active_q;

endmodule : rps_pin_select

// >>> tb/rps_pin_select_props.sv
// Concurrent checks on the ports of the pin select block.
// Assumes one pclk domain, a 12-bit byte address and the register map at 0x000 to 0x028.
module rps_pin_select_props #(
   parameter int unsigned ADDR_W    = 12,
   parameter bit          PKG_64PIN = 1'b0
) (
   // Clock and reset
   input wire logic                         pclk,
   input wire logic                         presetn,
   // APB
   input wire logic                         psel,
   input wire logic                         penable,
   input wire logic                         pwrite,
   input wire logic [ADDR_W-1:0]            paddr,
   input wire logic [31:0]                  pwdata,
   input wire logic [3:0]                   pstrb,
   input wire logic [31:0]                  prdata,
   input wire logic                         pready,
   input wire logic                         pslverr,
   // Output pins
   input wire logic [rps_pkg::OUT_PINS-1:0] port_data,
   input wire logic [rps_pkg::OUT_PINS-1:0] remappable_io_pin_out,
   input wire logic [rps_pkg::OUT_PINS-1:0] remap_active
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_ready; pready == (psel && penable); endproperty
   a_ready: assert property (p_ready) else $error("pready not tied to access phase");
   property p_err; psel && penable && paddr > 12'h028 |-> pslverr; endproperty
   a_err: assert property (p_err) else $error("unmapped access not refused");
   property p_err_idle; pslverr |-> psel && penable; endproperty
   a_err_idle: assert property (p_err_idle) else $error("pslverr outside access phase");
   property p_rsvd; psel && penable && !pwrite |-> (prdata & 32'hffff_c0c0) == 32'h0; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved read bits not zero");
   property p_sel_hi; psel && penable && !pwrite && paddr == 12'h004 |-> prdata[31:6] == 26'h0;
   endproperty
   a_sel_hi: assert property (p_sel_hi) else $error("select selector high bits set");
   property p_map_lo;
      psel && penable && pwrite && paddr == 12'h008 && pstrb[0] && pwdata[5:0] != 6'h00
         |-> ##2 remap_active[0];
   endproperty
   a_map_lo: assert property (p_map_lo) else $error("pin 0 not remapped");
   property p_map_hi;
      psel && penable && pwrite && paddr == 12'h008 && pstrb[1] && pwdata[13:8] == 6'h00
         |-> ##2 !remap_active[1];
   endproperty
   a_map_hi: assert property (p_map_hi) else $error("pin 1 remapped by function zero");
   property p_port; $past(presetn) |->
      ((remappable_io_pin_out ^ $past(port_data)) & ~remap_active) == '0;
   endproperty
   a_port: assert property (p_port) else $error("unmapped pin not under port control");
   property p_absent; PKG_64PIN |-> !remap_active[5] && !remap_active[15]; endproperty
   a_absent: assert property (p_absent) else $error("absent pin remapped");
endmodule : rps_pin_select_props

bind rps_pin_select rps_pin_select_props #(.ADDR_W(ADDR_W), .PKG_64PIN(PKG_64PIN)) u_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .port_data(port_data), .remappable_io_pin_out(remappable_io_pin_out),
   .remap_active(remap_active));

// >>> tb/rps_periph_model.sv
// Peripheral outputs and port data seen by the pin select block.
// Assumes pclk; the pattern moves every cycle so a stale route shows up.
module rps_periph_model (
   // Clock and reset
   input wire logic         pclk,
   input wire logic         presetn,
   // Peripheral and port levels
   output logic      [63:0] periph_out,
   output logic      [17:0] port_data
);
   logic [63:0] pat_q;
   logic [63:0] pat_d;
   always_comb begin
      pat_d = {pat_q[62:0], pat_q[63] ^ pat_q[60]};
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) pat_q <= 64'h0123_4567_89ab_cdef;
      else pat_q <= pat_d;
   end
   assign periph_out = pat_q;
   assign port_data  = ~pat_q[40:23];
endmodule : rps_periph_model

// >>> tb/testbench.sv
// Self-checking bench for the pin select block, 64-pin variant.
// Assumes the block answers APB with zero wait states and routes inputs in 3 edges.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic        spi_clk, spi_dat, spi_sel;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  pstrb;
   logic [63:0] pins, periph, prev_periph;
   logic [17:0] port, prev_port, pin_out, active;
   logic [15:0] lf;
   logic [5:0]  a, b, c, f;
   int          num_errors, tests_run, cycles;

   rps_pin_select #(.PKG_64PIN(1'b1)) u_rps_pin_select (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .remappable_io_pin_in(pins), .spi3_clock_input(spi_clk), .spi3_data_input(spi_dat),
      .spi3_select_input(spi_sel), .periph_out(periph), .port_data(port),
      .remappable_io_pin_out(pin_out), .remap_active(active));
   rps_periph_model u_rps_periph_model (.pclk(pclk), .presetn(presetn), .periph_out(periph),
      .port_data(port));

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   // Registers 1, 4 and 9 keep only their low field on this variant
   function automatic logic [31:0] mask(input int k);
      return (k == 1 || k == 4 || k == 9) ? 32'h0000_003f : 32'h0000_3f3f;
   endfunction : mask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= ad; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the bench's cycle ceiling ends a wait that never completes
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb
   task automatic stop_test;
      $display("errors %0d comparisons %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : stop_test

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   // Values the output flops captured at the last edge
   always @(posedge pclk) begin
      prev_periph <= periph;
      prev_port <= port;
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         stop_test();
      end
   end

   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
      pwdata = 32'h0; pstrb = 4'hf; pins = 64'h0; lf = 16'h004f;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      for (int k = 0; k < 11; k++) begin
         apb(1'b0, 12'(k * 4), 32'h0);
         check(rd, k == 0 ? 32'h3f3f : k == 1 ? 32'h003f : 32'h0);
      end
      $display("reset values done");
      for (int k = 0; k < 11; k++) begin
         lf = lfsr(lf);
         apb(1'b1, 12'(k * 4), {lf, ~lf});
         apb(1'b0, 12'(k * 4), 32'h0);
         check(rd, {lf, ~lf} & mask(k));
      end
      apb(1'b1, 12'h02c, 32'hffff_ffff);
      check(err, 1'b1);
      apb(1'b0, 12'h02c, 32'h0);
      check(err, 1'b1);
      check(rd, 32'h0);
      $display("register access done");
      for (int i = 0; i < 8; i++) begin
         lf = lfsr(lf);
         {a, b, c} = (i == 0) ? {6'h00, 6'h3f, 6'h01} : {lf[5:0], lf[13:8], lf[11:6]};
         apb(1'b1, 12'h000, {18'h0, b, 2'b00, a});
         apb(1'b1, 12'h004, {26'h0, c});
         pins <= {lf, ~lf, lf ^ 16'h5a5a, lf};
         repeat (4) @(posedge pclk);
         #1;
         check(spi_clk, pins[b]);
         check(spi_dat, pins[a]);
         check(spi_sel, pins[c]);
      end
      $display("input routing done");
      for (int p = 0; p < 18; p++) begin
         lf = lfsr(lf);
         f = (p % 6 == 0) ? 6'h00 : lf[5:0];
         apb(1'b1, 12'(8 + (p / 2) * 4), (p % 2) ? {18'h0, f, 8'h00} : {26'h0, f});
         repeat (3) @(posedge pclk);
         #1;
         if (p == 5 || p == 15 || f == 6'h00) check(pin_out[p], prev_port[p]);
         else check(pin_out[p], prev_periph[f]);
         check(active[p], p != 5 && p != 15 && f != 6'h00);
      end
      $display("output mapping done");
      // Reset in mid-run must bring every field back to its power-on value
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      check(active, 18'h0);
      presetn <= 1'b1;
      for (int k = 0; k < 11; k++) begin
         apb(1'b0, 12'(k * 4), 32'h0);
         check(rd, k == 0 ? 32'h3f3f : k == 1 ? 32'h003f : 32'h0);
      end
      // A write with no byte lane enabled changes nothing
      pstrb <= 4'h0;
      apb(1'b1, 12'h000, 32'h0);
      pstrb <= 4'hf;
      apb(1'b0, 12'h000, 32'h0);
      check(rd, 32'h3f3f);
      $display("mid-run reset done");
      stop_test();
   end
endmodule : testbench
